// >>> rtl/lfsc_controller.sv
// controller end: issues mode switches, detection reads and data loads
`timescale 1ns/1ps
`default_nettype none
module lfsc_controller
    import lfsc_pkg::*;
#(
    parameter int unsigned CHANNELS = LFSC_CHANNELS,
    parameter int unsigned DETECT_CYCLES = LFSC_DETECT_MIN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    lfsc_if.controller pins,
    input wire logic start_mode,
    input wire logic mode_sel,
    input wire logic start_detect,
    input wire logic start_write,
    input wire logic [CHANNELS-1:0] write_data,
    output logic busy,
    output logic [CHANNELS-1:0] read_data,
    output logic read_valid
);
    import lfsc_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_MODE = 4'h2,
        S_DET = 4'h4,
        S_SHIFT = 4'h8
    } lfsc_state_e;

    lfsc_state_e state_reg;
    logic [15:0] cnt_reg;
    logic [CHANNELS-1:0] tx_reg;
    logic do_latch_reg;
    logic oe_n_reg;
    logic le_reg;
    logic si_reg;

    assign pins.output_enable_n = oe_n_reg;
    assign pins.latch_strobe = le_reg;
    assign pins.serial_in = si_reg;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            cnt_reg <= 16'h0;
            tx_reg <= '0;
            do_latch_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            le_reg <= 1'b0;
            si_reg <= 1'b0;
            busy <= 1'b0;
            read_data <= '0;
            read_valid <= 1'b0;
        end else if (clk_en) begin
            read_valid <= 1'b0;
            le_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    oe_n_reg <= 1'b1;
                    cnt_reg <= 16'h0;
                    if (start_mode) begin
                        state_reg <= S_MODE;
                        busy <= 1'b1;
                    end else if (start_detect) begin
                        state_reg <= S_DET;
                        oe_n_reg <= 1'b0;
                        busy <= 1'b1;
                    end else if (start_write) begin
                        state_reg <= S_SHIFT;
                        tx_reg <= write_data;
                        do_latch_reg <= 1'b1;
                        busy <= 1'b1;
                    end
                end
                S_MODE: begin
                    // oe_n low for one sample between highs, strobe level on 4th
                    cnt_reg <= cnt_reg + 16'h1;
                    oe_n_reg <= (cnt_reg != 16'h0);
                    if (cnt_reg == 16'h2) begin
                        le_reg <= mode_sel;
                    end
                    if (cnt_reg == 16'h3) begin
                        state_reg <= S_IDLE;
                        busy <= 1'b0;
                    end
                end
                S_DET: begin
                    // oe_n held low long enough that the last low sample is late enough
                    cnt_reg <= cnt_reg + 16'h1;
                    if (cnt_reg >= 16'(DETECT_CYCLES + LFSC_DETECT_ZEROS)) begin
                        oe_n_reg <= 1'b1;
                        state_reg <= S_SHIFT;
                        cnt_reg <= 16'h0;
                        tx_reg <= '0;
                        do_latch_reg <= 1'b0;
                    end
                end
                S_SHIFT: begin
                    si_reg <= tx_reg[CHANNELS-1];
                    tx_reg <= {tx_reg[CHANNELS-2:0], 1'b0};
                    cnt_reg <= cnt_reg + 16'h1;
                    // serial_out already shows the msb before the first shift edge
                    if (cnt_reg != 16'(CHANNELS)) begin
                        read_data <= {read_data[CHANNELS-2:0], pins.serial_out};
                    end
                    if (cnt_reg == 16'(CHANNELS)) begin
                        le_reg <= do_latch_reg;
                        read_valid <= !do_latch_reg;
                        state_reg <= S_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule : lfsc_controller
`default_nettype wire

// >>> include/lfsc_pkg.sv
// package: constants shared by the fault status capture device and controller ends
package lfsc_pkg;
    localparam int unsigned LFSC_CHANNELS = 16;
    localparam logic [2:0] LFSC_MODE_PATTERN = 3'h5;
    localparam int unsigned LFSC_MODE_SAMPLE_EDGE = 4;
    localparam int unsigned LFSC_DETECT_ZEROS = 3;
    localparam int unsigned LFSC_CLK_MHZ = 50;
    localparam int unsigned LFSC_DETECT_MIN_NS = 2000;
    localparam int unsigned LFSC_DETECT_MIN_CYCLES =
        (LFSC_DETECT_MIN_NS * LFSC_CLK_MHZ + 999) / 1000;
    localparam logic LFSC_MODE_NORMAL = 1'b0;
    localparam logic LFSC_MODE_DETECT = 1'b1;
endpackage : lfsc_pkg

// >>> include/lfsc_if.sv
// interface: serial and strobe pins between controller and device
`timescale 1ns/1ps
`default_nettype none
interface lfsc_if;
    logic serial_in;
    logic serial_out;
    logic latch_strobe;
    logic output_enable_n;
    modport device (
        input serial_in,
        input latch_strobe,
        input output_enable_n,
        output serial_out
    );
    modport controller (
        output serial_in,
        output latch_strobe,
        output output_enable_n,
        input serial_out
    );
endinterface : lfsc_if
`default_nettype wire

// >>> rtl/lfsc_device.sv
// device end: mode switching, fault capture, shift register and output latch
// Function
// - oe_n 101 then fourth edge latch picks mode
// - power-on defaults to normal mode
// - detect mode oe_n falling enables sinks, detects
// - controller holds three low samples while enabled
// - last low sample at least 2us after fall
// - last low sample loads fault bits into shifter
// - no shifting while oe_n low in detect
// - detection sequence sampled on rising clock
// - oe_n rising turns sinks off, ends detection
// - after detection shift out captured bits
// - oe_n not low keeps shifting every clock
// - latch strobe pulse copies shifter to latch
`timescale 1ns/1ps
`default_nettype none
module lfsc_device
    import lfsc_pkg::*;
#(
    parameter int unsigned CHANNELS = LFSC_CHANNELS
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    lfsc_if.device pins,
    input wire logic [CHANNELS-1:0] fault_status,
    output logic [CHANNELS-1:0] latch_out,
    output logic sinks_on,
    output logic detect_mode,
    output logic capture_done
);
    import lfsc_pkg::*;

    logic [2:0] oe_hist_reg;
    logic [2:0] mode_cnt_reg;
    logic mode_reg;
    logic [1:0] zero_cnt_reg;
    logic [CHANNELS-1:0] shift_reg;
    logic so_reg;
    logic le_reg;
    logic capture;
    logic shift_hold;

    // oe_n sampled history on rising edges; newest in bit 0
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            oe_hist_reg <= 3'h7;
        end else if (clk_en) begin
            oe_hist_reg <= {oe_hist_reg[1:0], pins.output_enable_n};
        end
    end

    // pattern seen at edge 3; latch strobe decides at edge 4
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mode_cnt_reg <= 3'h0;
            mode_reg <= LFSC_MODE_NORMAL;
        end else if (clk_en) begin
            if (mode_cnt_reg != 3'h0) begin
                mode_cnt_reg <= 3'h0;
                mode_reg <= pins.latch_strobe;
            end else if ({oe_hist_reg[1:0], pins.output_enable_n} == LFSC_MODE_PATTERN) begin
                mode_cnt_reg <= 3'(LFSC_MODE_SAMPLE_EDGE - 3);
            end
        end
    end

    // shifting holds only while oe_n is low in detect mode
    assign shift_hold = (mode_reg == LFSC_MODE_DETECT) && !pins.output_enable_n;

    // the last low sample is only known once oe_n rises, so every low sample
    // from the third on reloads; the final one leaves its status behind
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            zero_cnt_reg <= 2'h0;
        end else if (clk_en) begin
            if (pins.output_enable_n) begin
                zero_cnt_reg <= 2'h0;
            end else if (mode_reg == LFSC_MODE_DETECT) begin
                if (zero_cnt_reg != 2'(LFSC_DETECT_ZEROS - 1)) begin
                    zero_cnt_reg <= zero_cnt_reg + 2'h1;
                end
            end
        end
    end

    // timing of the last low sample is the controller's duty
    assign capture = shift_hold &&
                     (zero_cnt_reg == 2'(LFSC_DETECT_ZEROS - 1));

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            shift_reg <= '0;
            so_reg <= 1'b0;
        end else if (clk_en) begin
            if (capture) begin
                shift_reg <= fault_status;
                so_reg <= fault_status[CHANNELS-1];
            end else if (!shift_hold) begin
                shift_reg <= {shift_reg[CHANNELS-2:0], pins.serial_in};
                so_reg <= shift_reg[CHANNELS-2];
            end
        end
    end

    assign pins.serial_out = so_reg;

    // strobe level is reused as a mode select, so only its rising edge latches
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            le_reg <= 1'b0;
            latch_out <= '0;
        end else if (clk_en) begin
            le_reg <= pins.latch_strobe;
            if (pins.latch_strobe && !le_reg && mode_cnt_reg == 3'h0) begin
                latch_out <= shift_reg;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sinks_on <= 1'b0;
            detect_mode <= 1'b0;
            capture_done <= 1'b0;
        end else if (clk_en) begin
            sinks_on <= !pins.output_enable_n;
            detect_mode <= mode_reg;
            capture_done <= capture;
        end
    end
endmodule : lfsc_device
`default_nettype wire

// >>> tb/lfsc_monitor.sv
// checker: pin protocol assertions between controller and device
`timescale 1ns/1ps
`default_nettype none
module lfsc_monitor
    import lfsc_pkg::*;
#(
    parameter int unsigned DETECT_CYCLES = LFSC_DETECT_MIN_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic latch_strobe,
    input wire logic output_enable_n
);
    import lfsc_pkg::*;

    logic [2:0] hist_reg;
    logic mode_reg;
    logic [7:0] low_reg;
    logic [7:0] sh_reg;
    logic halt;
    // shifting stops only for a low enable in detect mode
    assign halt = mode_reg && !output_enable_n;
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hist_reg <= 3'h0;
            mode_reg <= LFSC_MODE_NORMAL;
        end else begin
            hist_reg <= {hist_reg[1:0], output_enable_n};
            if (hist_reg == LFSC_MODE_PATTERN) begin
                mode_reg <= latch_strobe;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn || output_enable_n) begin
            low_reg <= 8'h0;
        end else if (low_reg != 8'hFF) begin
            low_reg <= low_reg + 8'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn || halt) begin
            sh_reg <= 8'h0;
        end else if (sh_reg != 8'hFF) begin
            sh_reg <= sh_reg + 8'h1;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    sequence detect_end_s;
        mode_reg && $rose(output_enable_n);
    endsequence
    sequence held_low_s;
        halt && low_reg >= 8'h3;
    endsequence
    reset_pins_a: assert property ($rose(rstn) |-> output_enable_n && !latch_strobe)
        else $error("pins not idle after reset");
    reset_sdo_a: assert property ($rose(rstn) |-> !serial_out)
        else $error("serial out not low after reset");
    detect_three_a: assert property (detect_end_s |-> low_reg == 8'h1 || low_reg >= 8'h3)
        else $error("too few low samples");
    detect_wait_a: assert property (detect_end_s |-> low_reg == 8'h1 || low_reg >= DETECT_CYCLES)
        else $error("detect low too short");
    shift_halt_a: assert property (held_low_s |=> $stable(serial_out))
        else $error("shift during detect");
    shift_pass_a: assert property (sh_reg >= 8'h10 |-> serial_out == $past(serial_in, 16))
        else $error("serial path wrong");
    shift_deep_a: assert property (sh_reg >= 8'h11 |-> $past(serial_out) == $past(serial_in, 17))
        else $error("serial step wrong");
    strobe_pulse_a: assert property ($rose(latch_strobe) |=> !latch_strobe)
        else $error("strobe not a pulse");
    detect_c: cover property (detect_end_s);
endmodule : lfsc_monitor
`default_nettype wire

// >>> tb/tb.sv
// testbench: controller and device joined through the pin interface
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, x, g); end end
module tb;
    import lfsc_pkg::*;
    localparam int unsigned DC = 4;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic go_mode = 1'b0;
    logic go_det = 1'b0;
    logic go_wr = 1'b0;
    logic msel = 1'b0;
    logic [15:0] wdata = 16'h0;
    logic [15:0] fault = 16'h0;
    logic [15:0] rdata, lout, e;
    logic busy, rvalid, dmode;
    int errors = 0;
    int total_checks = 0;
    int seed = 90038;
    logic [15:0] exp_q[$];
    lfsc_if pins_if();
    lfsc_controller #(.DETECT_CYCLES(DC)) lfsc_controller_i (.ref_clk(ref_clk), .rstn(rstn),
        .clk_en(1'b1), .pins(pins_if.controller), .start_mode(go_mode), .mode_sel(msel),
        .start_detect(go_det), .start_write(go_wr), .write_data(wdata), .busy(busy),
        .read_data(rdata), .read_valid(rvalid));
    lfsc_device lfsc_device_i (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1),
        .pins(pins_if.device), .fault_status(fault), .latch_out(lout), .sinks_on(),
        .detect_mode(dmode), .capture_done());
    lfsc_monitor #(.DETECT_CYCLES(DC)) lfsc_monitor_i (.ref_clk(ref_clk), .rstn(rstn),
        .serial_in(pins_if.serial_in), .serial_out(pins_if.serial_out),
        .latch_strobe(pins_if.latch_strobe), .output_enable_n(pins_if.output_enable_n));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // k: 0 mode switch, 1 detect read, 2 data write
    task run(input int k);
        int n;
        @(negedge ref_clk);
        go_mode = (k == 0);
        go_det = (k == 1);
        go_wr = (k == 2);
        @(negedge ref_clk);
        {go_mode, go_det, go_wr} = 3'h0;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 300) begin
            errors++;
            end_of_test();
        end
        // latch updates on the edge after the strobe
        repeat (2) @(negedge ref_clk);
    endtask : run
    always @(posedge ref_clk) begin
        #1;
        if (rvalid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
            `CHK("read_data", e, rdata)
        end
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        `CHK("mode", LFSC_MODE_NORMAL, dmode)
        wdata = $random(seed);
        run(2);
        `CHK("latch_out", wdata, lout)
        $display("test normal write done");
        msel = 1'b1;
        run(0);
        `CHK("mode", LFSC_MODE_DETECT, dmode)
        for (int i = 0; i < 4; i++) begin
            // edge pattern first: both end bits set, so a lost end bit shows
            fault = (i == 0) ? 16'h8001 : $random(seed);
            exp_q.push_back(fault);
            run(1);
        end
        $display("test detect read done");
        wdata = $random(seed);
        run(2);
        `CHK("latch_out", wdata, lout)
        msel = 1'b0;
        run(0);
        `CHK("mode", LFSC_MODE_NORMAL, dmode)
        wdata = $random(seed);
        run(2);
        `CHK("latch_out", wdata, lout)
        `CHK("queue", 0, exp_q.size())
        $display("test mode return done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
